// File: hdl/lwc_map.vh
// Register addresses, frame fields, widths and reset values for the low-power wake configuration.
`ifndef LWC_MAP_VH
`define LWC_MAP_VH

// ----------------------------------------
// Register addresses (7-bit)
// ----------------------------------------
`define LWC_ADDR_CMPONLY_PROG  7'h12
`define LWC_ADDR_CMPONLY_GND   7'h13
`define LWC_ADDR_LPTHR_PROG    7'h14
`define LWC_ADDR_LPTHR_GND     7'h15
`define LWC_ADDR_ENTER_LP      7'h1C
`define LWC_ADDR_WAKE_PROG     7'h10
`define LWC_ADDR_WAKE_GND      7'h11

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define LWC_FRAME_BITS         32
`define LWC_ADDR_MSB           31
`define LWC_ADDR_LSB           25
`define LWC_RW_BIT             24
`define LWC_DATA_MSB           23
`define LWC_RSP_FAULT_BIT      23
`define LWC_RSP_INT_BIT        22
`define LWC_RSP_DATA_MSB       21

// ----------------------------------------
// Channel counts and reset values
// ----------------------------------------
`define LWC_NPROG              8
`define LWC_NGND_CMP           13
`define LWC_NGND_THR           14
`define LWC_RST_PROG           8'h00
`define LWC_RST_GND_CMP        13'h0000
`define LWC_RST_GND_THR        14'h0000
`define LWC_BITCNT_W           6

`endif

// File: hdl/lwc_config.v
// SPI-reached low-power wake comparator configuration with per-channel wake evaluation.
`timescale 1ns/1ps
`include "lwc_map.vh"

module lwc_config (
   // Clock and reset.
   input  wire        clk_sys,
   input  wire        rst_n,
   // SPI pins from the host, asynchronous to clk_sys.
   input  wire        spiSclk,
   input  wire        spiCsN,
   input  wire        spiMosi,
   output reg         spiMiso,
   // Status carried in every response.
   input  wire        faultStatus,
   input  wire        intFlag,
   // Wake enables held elsewhere in the device.
   input  wire [7:0]  wakeEnProg,
   input  wire [13:0] wakeEnGnd,
   // Channel configuration and low-power state.
   input  wire [7:0]  batterySwitchConfig,
   input  wire        lowPowerClk,
   input  wire        wakeRequest,
   // Comparator results: pin level, delta threshold, normal threshold, fixed 4.0 V threshold.
   input  wire [21:0] cmpLevel,
   input  wire [21:0] cmpDelta,
   input  wire [21:0] cmpNormal,
   input  wire [7:0]  cmpBattery,
   // Analog and state outputs.
   output reg  [21:0] pollCurrentEn,
   output reg  [21:0] comparatorEn,
   output reg  [21:0] useNormalThr,
   output reg  [21:0] channelState,
   output reg         pollTimerRun,
   output reg         lowPowerState,
   output reg         wakeOut
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg  [7:0]  cmpOnlyProg_q;
   reg  [12:0] cmpOnlyGnd_q;
   reg  [7:0]  lpThrProg_q;
   reg  [13:0] lpThrGnd_q;

   // Synchronisers: first stage read only by the second.
   reg  [2:0]  sclkSync_q;
   reg  [1:0]  csSync_q;
   reg  [1:0]  mosiSync_q;
   reg  [2:0]  lpClkSync_q;
   reg  [21:0] lvlMeta_q;
   reg  [21:0] lvlSync_q;
   reg  [21:0] lvlLp_q;

   reg  [31:0] shiftIn_q;
   reg  [23:0] shiftOut_q;
   reg  [5:0]  bitCnt_q;
   reg         armed_q;

   wire        csActive   = ~csSync_q[1];
   wire        sclkRise   = sclkSync_q[1] & ~sclkSync_q[2];
   wire        sclkFall   = ~sclkSync_q[1] & sclkSync_q[2];
   wire        lpTick     = lpClkSync_q[1] & ~lpClkSync_q[2];
   wire        frameDone  = csActive && sclkRise && (bitCnt_q == 6'd31);
   wire [31:0] frameWord  = {shiftIn_q[30:0], mosiSync_q[1]};
   wire [6:0]  frameAddr  = frameWord[`LWC_ADDR_MSB:`LWC_ADDR_LSB];
   wire        frameWr    = frameWord[`LWC_RW_BIT];
   wire [23:0] frameData  = frameWord[`LWC_DATA_MSB:0];

   // ----------------------------------------
   // Read-back selection
   // ----------------------------------------
   // Read data is built from the address captured after the first seven bits.
   reg  [21:0] readData;
   always @* begin
      case (shiftIn_q[6:0])
         `LWC_ADDR_CMPONLY_PROG: readData = {14'h0000, cmpOnlyProg_q};
         `LWC_ADDR_CMPONLY_GND:  readData = {9'h000, cmpOnlyGnd_q};
         `LWC_ADDR_LPTHR_PROG:   readData = {14'h0000, lpThrProg_q};
         `LWC_ADDR_LPTHR_GND:    readData = {8'h00, lpThrGnd_q};
         default:                readData = 22'h000000;
      endcase
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // The SPI pins, the low-power clock and cmpLevel pass two flops before any decision uses them.
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sclkSync_q  <= 3'h0;
         csSync_q    <= 2'h3;
         mosiSync_q  <= 2'h0;
         lpClkSync_q <= 3'h0;
         lvlMeta_q   <= 22'h000000;
         lvlSync_q   <= 22'h000000;
      end else begin
         sclkSync_q  <= {sclkSync_q[1:0], spiSclk};
         csSync_q    <= {csSync_q[0], spiCsN};
         mosiSync_q  <= {mosiSync_q[0], spiMosi};
         lpClkSync_q <= {lpClkSync_q[1:0], lowPowerClk};
         lvlMeta_q   <= cmpLevel;
         lvlSync_q   <= lvlMeta_q;
      end
   end

   // ----------------------------------------
   // SPI frame engine and register writes
   // ----------------------------------------
   // Bits shift in MSB first on the rising SCLK edge; response shifts out on the falling edge.
   // The response word is loaded once the address has arrived, so it reflects the addressed
   // register before this frame's write takes effect.
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         shiftIn_q     <= 32'h00000000;
         shiftOut_q    <= 24'h000000;
         bitCnt_q      <= 6'h00;
         armed_q       <= 1'b0;
         spiMiso       <= 1'b0;
         cmpOnlyProg_q <= `LWC_RST_PROG;
         cmpOnlyGnd_q  <= `LWC_RST_GND_CMP;
         lpThrProg_q   <= `LWC_RST_PROG;
         lpThrGnd_q    <= `LWC_RST_GND_THR;
         lowPowerState <= 1'b0;
      end else begin
         if (!csActive) begin
            bitCnt_q <= 6'h00;
            armed_q  <= 1'b0;
         end else if (sclkRise) begin
            shiftIn_q <= frameWord;
            bitCnt_q  <= bitCnt_q + 6'd1;
            if (bitCnt_q == 6'd7) begin
               // Fault and interrupt flags lead the register data.
               shiftOut_q <= {faultStatus, intFlag, readData};
               armed_q    <= 1'b1;
            end
         end else if (sclkFall && armed_q) begin
            spiMiso    <= shiftOut_q[23];
            shiftOut_q <= {shiftOut_q[22:0], 1'b0};
         end
         // Writes land only on a full 32-bit frame; shorter frames are dropped.
         if (frameDone && frameWr) begin
            case (frameAddr)
               `LWC_ADDR_CMPONLY_PROG: cmpOnlyProg_q <= frameData[7:0];
               `LWC_ADDR_CMPONLY_GND:  cmpOnlyGnd_q  <= frameData[12:0];
               `LWC_ADDR_LPTHR_PROG:   lpThrProg_q   <= frameData[7:0];
               `LWC_ADDR_LPTHR_GND:    lpThrGnd_q    <= frameData[13:0];
               `LWC_ADDR_ENTER_LP: begin
                  if (frameData == 24'h000000) begin
                     lowPowerState <= 1'b1;
                  end
               end
               default: ;
            endcase
         end else if (lowPowerState && wakeRequest) begin
            lowPowerState <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Per-channel evaluation
   // ----------------------------------------
   // Channels 0..7 are programmable, 8..21 are ground switches (ground 13 has no
   // comparator-only bit). Per-channel selects are built here and registered below in
   // one process, so every output vector has a single driver.
   wire [21:0] chanCmpOnly;
   wire [21:0] chanThrSel;
   wire [21:0] chanIsBat;
   wire [21:0] chanLpState;
   genvar ch;
   generate
      for (ch = 0; ch < 22; ch = ch + 1) begin : gChan
         if (ch < 8) begin : gProg
            assign chanCmpOnly[ch] = cmpOnlyProg_q[ch];
            assign chanThrSel[ch]  = lpThrProg_q[ch];
            assign chanIsBat[ch]   = batterySwitchConfig[ch];
            assign chanLpState[ch] = chanCmpOnly[ch] ? lvlLp_q[ch] :
                                     chanIsBat[ch] ? cmpBattery[ch] :
                                     chanThrSel[ch] ? cmpNormal[ch] : cmpDelta[ch];
         end else if (ch < 21) begin : gGnd
            assign chanCmpOnly[ch] = cmpOnlyGnd_q[ch - 8];
            assign chanThrSel[ch]  = lpThrGnd_q[ch - 8];
            assign chanIsBat[ch]   = 1'b0;
            assign chanLpState[ch] = chanCmpOnly[ch] ? lvlLp_q[ch] :
                                     chanThrSel[ch] ? cmpNormal[ch] : cmpDelta[ch];
         end else begin : gGndLast
            assign chanCmpOnly[ch] = 1'b0;
            assign chanThrSel[ch]  = lpThrGnd_q[ch - 8];
            assign chanIsBat[ch]   = 1'b0;
            assign chanLpState[ch] = chanThrSel[ch] ? cmpNormal[ch] : cmpDelta[ch];
         end
      end
   endgenerate

   // Outside the low-power state the settings have no effect on any channel.
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         comparatorEn  <= 22'h000000;
         pollCurrentEn <= 22'h000000;
         useNormalThr  <= 22'h3FFFFF;
         channelState  <= 22'h000000;
      end else if (!lowPowerState) begin
         comparatorEn  <= 22'h3FFFFF;
         pollCurrentEn <= 22'h3FFFFF;
         useNormalThr  <= 22'h3FFFFF;
         channelState  <= cmpNormal;
      end else begin
         comparatorEn  <= 22'h3FFFFF;
         pollCurrentEn <= ~chanCmpOnly;
         useNormalThr  <= chanIsBat | chanThrSel;
         channelState  <= chanLpState;
      end
   end

   // ----------------------------------------
   // Low-power sampling, wake and polling timer
   // ----------------------------------------
   // Comparator-only inputs are resampled once per rising low-power clock edge, so a pulse
   // shorter than that clock period may be missed; that is the intended bandwidth.
   wire [21:0] cmpOnlyMask = {1'b0, cmpOnlyGnd_q, cmpOnlyProg_q};
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lvlLp_q      <= 22'h000000;
         wakeOut      <= 1'b0;
         pollTimerRun <= 1'b0;
      end else begin
         if (lpTick || !lowPowerState) begin
            lvlLp_q <= lvlSync_q;
         end
         wakeOut <= lowPowerState && lpTick &&
                    (|((lvlSync_q ^ lvlLp_q) & cmpOnlyMask));
         pollTimerRun <= lowPowerState &&
                         ((|wakeEnProg) || (|wakeEnGnd));
      end
   end

endmodule

// File: verif/lwc_config_monitor.sv
// Port-level assertions for the low-power wake configuration block, bound into it.
`timescale 1ns/1ps
module lwc_monitor (
   // Clock and reset.
   input wire        clk_sys,
   input wire        rst_n,
   // Inputs of the block.
   input wire        spiCsN,
   input wire        wakeRequest,
   input wire [7:0]  wakeEnProg,
   input wire [7:0]  batterySwitchConfig,
   input wire [7:0]  cmpBattery,
   input wire [13:0] wakeEnGnd,
   input wire [21:0] cmpDelta,
   input wire [21:0] cmpNormal,
   // Outputs under watch.
   input wire [21:0] pollCurrentEn,
   input wire [21:0] comparatorEn,
   input wire [21:0] useNormalThr,
   input wire [21:0] channelState,
   input wire        pollTimerRun,
   input wire        lowPowerState,
   input wire        wakeOut
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Outputs are registered, so a mode only counts once it has held for two edges.
   sequence lpSteady;
      lowPowerState && $past(lowPowerState) && $past(lowPowerState, 2)
         && $stable({cmpDelta, cmpNormal, cmpBattery});
   endsequence
   sequence nmSteady;
      !lowPowerState && !$past(lowPowerState) && $past(rst_n, 2) && $stable(cmpNormal);
   endsequence
   // Comparator-only channels follow the raw level, so they are left out of judging.
   wire [21:0] judged = ~(comparatorEn & ~pollCurrentEn);
   wire [21:0] pick   = (useNormalThr & cmpNormal) | (~useNormalThr & cmpDelta);
   chk_normal_mode: assert property (
      nmSteady |-> &pollCurrentEn && &comparatorEn && &useNormalThr)
      else $error("normal mode enables wrong");
   chk_normal_state: assert property (nmSteady |-> channelState == cmpNormal)
      else $error("normal mode state wrong");
   chk_gnd_select: assert property (
      lpSteady |-> ((channelState ^ pick) & judged & 22'h3FFF00) == 22'h000000)
      else $error("ground channel threshold wrong");
   chk_battery_thr: assert property (
      lpSteady |-> ((channelState[7:0] ^ cmpBattery) & batterySwitchConfig & judged[7:0]) == 8'h00)
      else $error("battery channel threshold wrong");
   // The timer flop follows the enables of one cycle earlier.
   chk_poll_timer: assert property (
      lpSteady ##0 ($past(wakeEnProg) == 8'h00 && $past(wakeEnGnd) == 14'h0000)
      |-> !pollTimerRun)
      else $error("poll timer runs with no wake enable");
   chk_poll_running: assert property (
      lpSteady ##0 ($past(wakeEnProg) != 8'h00 || $past(wakeEnGnd) != 14'h0000)
      |-> pollTimerRun)
      else $error("poll timer stopped with a wake enable set");
   chk_comparator_on: assert property (lpSteady |-> &comparatorEn)
      else $error("comparator off in low power");
   chk_lp_by_frame: assert property ($rose(lowPowerState) |-> !$past(spiCsN, 2))
      else $error("low power entered outside a frame");
   chk_wake_pulse: assert property (wakeOut |-> $past(lowPowerState) ##1 !wakeOut)
      else $error("wake pulse wrong");
   chk_lp_exit: assert property (lowPowerState && wakeRequest |=> !lowPowerState)
      else $error("low power exit missed");
   cov_wake: cover property (wakeOut);
   cov_enter: cover property ($rose(lowPowerState));
   cov_exit: cover property ($fell(lowPowerState));
endmodule
bind lwc_config lwc_monitor u_lwc_monitor (
   .clk_sys             (clk_sys),
   .rst_n               (rst_n),
   .spiCsN              (spiCsN),
   .wakeRequest         (wakeRequest),
   .wakeEnProg          (wakeEnProg),
   .batterySwitchConfig (batterySwitchConfig),
   .cmpBattery          (cmpBattery),
   .wakeEnGnd           (wakeEnGnd),
   .cmpDelta            (cmpDelta),
   .cmpNormal           (cmpNormal),
   .pollCurrentEn       (pollCurrentEn),
   .comparatorEn        (comparatorEn),
   .useNormalThr        (useNormalThr),
   .channelState        (channelState),
   .pollTimerRun        (pollTimerRun),
   .lowPowerState       (lowPowerState),
   .wakeOut             (wakeOut)
);

// File: verif/lwc_host_model.sv
// Host serial master that frames 32-bit words for the configuration block.
`timescale 1ns/1ps
module lwc_host_model (
   // Pacing clock.
   input  wire clk_sys,
   // Serial pins.
   output reg  spiSclk,
   output reg  spiCsN,
   output reg  spiMosi,
   input  wire spiMiso
);
   integer i;
   // Serial clock idles low and stands still between frames.
   initial begin
      spiSclk = 1'h0;
      spiCsN  = 1'h1;
      spiMosi = 1'h0;
   end
   // Half a serial period is four system clocks; n below 32 cuts a frame short on purpose.
   task xfer(input [31:0] w, input integer n, output [23:0] r);
      begin
         r = 24'h000000;
         @(posedge clk_sys) spiCsN <= 1'h0;
         for (i = 0; i < n; i = i + 1) begin
            spiMosi <= w[31 - i];
            repeat (4) @(posedge clk_sys);
            spiSclk <= 1'h1;
            repeat (4) @(posedge clk_sys);
            if (i >= 8) r = {r[22:0], spiMiso};
            spiSclk <= 1'h0;
         end
         repeat (8) @(posedge clk_sys);
         spiCsN  <= 1'h1;
         spiMosi <= ~spiMosi; // A released line must not keep its last bit.
         repeat (8) @(posedge clk_sys);
      end
   endtask
endmodule

// File: verif/lwc_config_tb_top.sv
// Self-checking bench for the low-power wake configuration block.
`timescale 1ns/1ps
module lwc_config_tb_top;
   reg         clk_sys, rst_n, faultStatus, intFlag, lowPowerClk, wakeRequest;
   reg  [7:0]  wakeEnProg, batterySwitchConfig, cmpBattery;
   reg  [13:0] wakeEnGnd;
   reg  [21:0] cmpLevel, cmpDelta, cmpNormal, m;
   reg  [23:0] rsp;
   wire        spiSclk, spiCsN, spiMosi, spiMiso, pollTimerRun, lowPowerState, wakeOut;
   wire [21:0] pollCurrentEn, comparatorEn, useNormalThr, channelState;
   integer     error_cnt, total_checks, k;
   lwc_config u_lwc_config (.clk_sys(clk_sys), .rst_n(rst_n), .spiSclk(spiSclk),
      .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso), .faultStatus(faultStatus),
      .intFlag(intFlag), .wakeEnProg(wakeEnProg), .wakeEnGnd(wakeEnGnd),
      .batterySwitchConfig(batterySwitchConfig), .lowPowerClk(lowPowerClk),
      .wakeRequest(wakeRequest), .cmpLevel(cmpLevel), .cmpDelta(cmpDelta),
      .cmpNormal(cmpNormal), .cmpBattery(cmpBattery), .pollCurrentEn(pollCurrentEn),
      .comparatorEn(comparatorEn), .useNormalThr(useNormalThr),
      .channelState(channelState), .pollTimerRun(pollTimerRun),
      .lowPowerState(lowPowerState), .wakeOut(wakeOut));
   lwc_host_model u_lwc_host_model (.clk_sys(clk_sys), .spiSclk(spiSclk),
      .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso));
   task chk(input [23:0] seen, input [23:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [6:0] a, input [23:0] d);
      u_lwc_host_model.xfer({a, 1'h1, d}, 32, rsp);
   endtask
   task rd(input [6:0] a);
      u_lwc_host_model.xfer({a, 1'h0, 24'h000000}, 32, rsp);
   endtask
   task report_and_stop;
      begin
         $display("checks=%0d errors=%0d", total_checks, error_cnt);
         if (error_cnt == 0 && total_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Power-on contents and normal-mode outputs; fault high and interrupt low in the reply.
   task t_reset;
      begin
         chk({2'h0, pollCurrentEn & comparatorEn & useNormalThr}, 24'h3FFFFF);
         chk({2'h0, channelState}, {2'h0, cmpNormal});
         for (k = 0; k < 4; k = k + 1) begin
            rd(7'h12 + k[6:0]);
            chk(rsp, 24'h800000);
         end
      end
   endtask
   // All-ones writes keep only the channel bits; a 31-bit frame must write nothing.
   task t_masks;
      begin
         @(posedge clk_sys) {faultStatus, intFlag} <= 2'h1;
         for (k = 0; k < 4; k = k + 1) begin
            m = (k == 1) ? 22'h001FFF : (k == 3) ? 22'h003FFF : 22'h0000FF;
            wr(7'h12 + k[6:0], 24'hFFFFFF);
            rd(7'h12 + k[6:0]);
            chk(rsp, {2'h1, m});
         end
         u_lwc_host_model.xfer({7'h12, 1'h1, 24'h000000}, 31, rsp);
         rd(7'h12);
         chk(rsp, 24'h4000FF);
      end
   endtask
   // Channel 0 comparator-only, ground 0 on normal threshold, channel 1 a battery switch.
   task t_lowpower;
      begin
         wr(7'h12, 24'h000001);
         wr(7'h13, 24'h000000);
         wr(7'h14, 24'h000000);
         // Ground 0 on the normal threshold; its comparator input stands for enough current.
         wr(7'h15, 24'h000001);
         wr(7'h1C, 24'h000001);
         chk({23'h0, lowPowerState}, 24'h000000);
         wr(7'h1C, 24'h000000);
         chk({23'h0, lowPowerState}, 24'h000001);
         chk({23'h0, pollTimerRun}, 24'h000000);
         chk({22'h0, comparatorEn[0], pollCurrentEn[0]}, 24'h000002);
         wakeEnGnd <= 14'h3FFF;
         repeat (20) @(posedge clk_sys);
         chk({22'h0, useNormalThr[9:8]}, 24'h000001);
         chk({22'h0, channelState[9:8]}, 24'h000003);
         chk({23'h0, channelState[1]}, {23'h0, cmpBattery[1]});
         chk({23'h0, pollTimerRun}, 24'h000001);
         cmpLevel[0] <= ~cmpLevel[0];
         for (k = 0; k < 40 && wakeOut !== 1'h1; k = k + 1)
            @(posedge clk_sys) #1;
         chk({23'h0, wakeOut}, 24'h000001);
         @(posedge clk_sys) wakeRequest <= 1'h1;
         @(posedge clk_sys) {wakeRequest, wakeEnGnd} <= 15'h0000;
         repeat (2) @(posedge clk_sys);
         chk({23'h0, lowPowerState}, 24'h000000);
      end
   endtask
   // System clock, and a low-power clock of unrelated phase.
   initial begin
      clk_sys = 1'h0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      lowPowerClk = 1'h0;
      #7;
      forever #200 lowPowerClk = ~lowPowerClk;
   end
   // Watchdog well beyond the twenty frames of the run.
   initial begin
      #2000000;
      error_cnt = error_cnt + 1;
      report_and_stop;
   end
   // Main sequence.
   initial begin
      {rst_n, faultStatus, intFlag, wakeRequest} = 4'h4;
      {wakeEnProg, wakeEnGnd, cmpLevel, cmpBattery} = 52'h0;
      batterySwitchConfig = 8'h02;
      cmpNormal = 22'h155555;
      cmpDelta = 22'h2AAAAA;
      {error_cnt, total_checks} = 64'h0;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'h1;
      repeat (4) @(posedge clk_sys);
      t_reset;
      t_masks;
      t_lowpower;
      report_and_stop;
   end
endmodule
